// file: rtl/fcl_flash_control.sv
// Flash control register, lower bits, with read source and operation gating
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Bit 11 set reads sector latches; clear (reset) reads the array.
// - Bit 10 set forces all program data latch bits to one; resets clear.
// - Bit 9 set puts the flash into power-down; resets clear.
// - Bits 8 and 3 read zero; software leaves them unchanged.
// - Bit 7 set permits program and erase; reset clear keeps them off.
// - Bit 6 set reads the index sector; clear (reset) reads the array.
// - Bit 5 set reads the program data latches for verification.
// - Bit 2 is active-low program/erase enable; resets to one (disabled).
// - Bit 1 set selects program and data load; clear (reset) selects erase.
// - Bit 0 set keeps flash active (reset); clear puts it in standby.
// - Data-latch and index-sector reads bypass buffering, wait states every beat.
module fcl_flash_control #(
  parameter int WST_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [11:0]       addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [31:0]       rdata,
  // Read beats from the bus bridge
  input  wire logic [WST_W-1:0]  wst_count,
  input  wire logic              beat_req,
  input  wire logic              beat_first,
  output var  logic              beat_ready,
  output var  logic              buf_bypass,
  // Operation handshake with the sequencer
  input  wire logic              op_start,
  input  wire logic              op_done,
  output var  logic              op_go,
  // Flash array controls
  output var  logic              flash_active,
  output var  logic              flash_powerdown,
  output var  logic              latch_preset,
  output var  logic              async_read,
  output var  logic [1:0]        read_src,
  output var  logic              program_sel,
  output var  logic              erase_sel,
  output var  logic              pe_allowed
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (WST_W < 1 || WST_W > 16) begin : g_bad_width
      $error("WST_W must lie between 1 and 16");
    end
    if (fcl_pkg::FCL_ST_REFUSED_LO + fcl_pkg::FCL_REFUSED_W > 32) begin : g_bad_status
      $error("Refused count must fit in the status word");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]               ctrl_reg;
  logic [31:0]               ctrl_next;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;
  fcl_pkg::fcl_op_state_t    op_state_reg;
  fcl_pkg::fcl_op_state_t    op_state_next;
  logic                      op_go_reg;
  logic                      op_go_next;
  logic [fcl_pkg::FCL_REFUSED_W-1:0] refused_reg;
  logic [fcl_pkg::FCL_REFUSED_W-1:0] refused_next;
  fcl_pkg::fcl_read_src_t    src_reg;
  logic                      active_reg;
  logic                      pdown_reg;
  logic                      preset_reg;
  logic                      async_reg;
  logic                      prog_reg;
  logic                      erase_reg;
  logic                      allowed_reg;

  wire logic                 hit_ctrl;
  wire logic                 hit_status;
  wire logic                 wr_ctrl;
  wire logic                 wr_status;
  wire logic                 allowed;
  wire logic                 powered;
  wire logic                 refuse;
  wire logic                 accept;
  wire logic [31:0]          ctrl_view;
  logic [31:0]               status_view;
  wire logic                 st_op_busy;
  wire logic                 st_serving;
  wire logic                 refused_full;
  wire logic                 op_idle;
  wire logic                 program_pick;
  fcl_pkg::fcl_read_src_t    src_sel;

  fcl_read_if #(.WST_W(WST_W)) rif ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Two words decode; any other address ignores writes and reads zero
  assign hit_ctrl   = (addr == fcl_pkg::FCL_CTRL_OFFSET);
  assign hit_status = (addr == fcl_pkg::FCL_STATUS_OFFSET);
  assign wr_ctrl    = wr && hit_ctrl;
  assign wr_status  = wr && hit_status;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Only documented bits store; reserved and upper bits stay zero
  assign ctrl_next = wr_ctrl ? (wdata & fcl_pkg::FCL_CTRL_WMASK) : ctrl_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= fcl_pkg::FCL_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------
  // Decoded control
  // ----------------------------------------
  // Both gates must agree before anything is burned
  assign allowed = ctrl_reg[fcl_pkg::FCL_PROG_ERASE_UNPROTECT] &&
                   !ctrl_reg[fcl_pkg::FCL_PROG_ERASE_ENABLE_N];
  // Standby or power-down leaves the array unable to serve
  assign powered = ctrl_reg[fcl_pkg::FCL_FLASH_ACTIVE_SEL] &&
                   !ctrl_reg[fcl_pkg::FCL_FLASH_POWERDOWN];
  // One select bit drives both, so program and erase never overlap
  assign program_pick = ctrl_reg[fcl_pkg::FCL_PROGRAM_NOT_ERASE];

  // Several selects at once: latch verify outranks index, index outranks sector
  always_comb begin
    if (ctrl_reg[fcl_pkg::FCL_DATA_LATCH_READ_SEL]) begin
      src_sel = fcl_pkg::FCL_SRC_DATA_LATCH;
    end else if (ctrl_reg[fcl_pkg::FCL_INDEX_SECTOR_SEL]) begin
      src_sel = fcl_pkg::FCL_SRC_INDEX_SECTOR;
    end else if (ctrl_reg[fcl_pkg::FCL_SECTOR_LATCH_READ_SEL]) begin
      src_sel = fcl_pkg::FCL_SRC_SECTOR_LATCH;
    end else begin
      src_sel = fcl_pkg::FCL_SRC_ARRAY;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_reg     <= fcl_pkg::FCL_SRC_ARRAY;
      active_reg  <= 1'b1;
      pdown_reg   <= 1'b0;
      preset_reg  <= 1'b0;
      async_reg   <= 1'b0;
      prog_reg    <= 1'b0;
      erase_reg   <= 1'b0;
      allowed_reg <= 1'b0;
    end else begin
      src_reg     <= src_sel;
      active_reg  <= ctrl_reg[fcl_pkg::FCL_FLASH_ACTIVE_SEL];
      pdown_reg   <= ctrl_reg[fcl_pkg::FCL_FLASH_POWERDOWN];
      preset_reg  <= ctrl_reg[fcl_pkg::FCL_LATCH_PRESET];
      async_reg   <= ctrl_reg[fcl_pkg::FCL_ASYNC_READ_SEL];
      prog_reg    <= allowed && program_pick;
      erase_reg   <= allowed && !program_pick;
      allowed_reg <= allowed;
    end
  end

  // ----------------------------------------
  // Program and erase operation gating
  // ----------------------------------------
  // A start while protected, disabled or asleep is dropped and counted
  assign op_idle = (op_state_reg == fcl_pkg::FCL_OP_IDLE);
  assign accept  = op_start && allowed && powered && op_idle;
  assign refuse = op_start && !accept;

  always_comb begin
    op_state_next = op_state_reg;
    op_go_next    = 1'b0;
    case (op_state_reg)
      fcl_pkg::FCL_OP_IDLE: begin
        if (accept) begin
          op_state_next = fcl_pkg::FCL_OP_RUN;
          op_go_next    = 1'b1;
        end
      end
      fcl_pkg::FCL_OP_RUN: begin
        if (op_done) begin
          op_state_next = fcl_pkg::FCL_OP_DONE;
        end
      end
      // One settling cycle so a new start never meets the done pulse
      fcl_pkg::FCL_OP_DONE: begin
        op_state_next = fcl_pkg::FCL_OP_IDLE;
      end
      default: begin
        op_state_next = fcl_pkg::FCL_OP_IDLE;
      end
    endcase
  end

  // Refusal wins over a clear in the same cycle and counts as one; the count
  // saturates so a flood of refused starts never wraps back to zero
  assign refused_full = (refused_reg == '1) && !wr_status;

  always_comb begin
    refused_next = refused_reg;
    if (wr_status) begin
      refused_next = '0;
    end
    if (refuse && !refused_full) begin
      refused_next = wr_status ? {{(fcl_pkg::FCL_REFUSED_W-1){1'b0}}, 1'b1}
                               : refused_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_state_reg <= fcl_pkg::FCL_OP_IDLE;
      op_go_reg    <= 1'b0;
      refused_reg  <= '0;
    end else begin
      op_state_reg <= op_state_next;
      op_go_reg    <= op_go_next;
      refused_reg  <= refused_next;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Timer sees the registered source, so a select change reaches it a cycle later
  assign rif.read_src   = src_reg;
  assign rif.async_read = async_reg;
  assign rif.enable     = powered;
  assign rif.wst        = wst_count;
  assign rif.beat_req   = beat_req;
  assign rif.beat_first = beat_first;

  fcl_read_path #(
    .WST_W (WST_W)
  ) u_read_path (
    .clk (clk),
    .rst (rst),
    .rd  (rif.path)
  );

  // ----------------------------------------
  // Register read back
  // ----------------------------------------
  assign ctrl_view = ctrl_reg & fcl_pkg::FCL_CTRL_WMASK;

  // Status fields sit at the package positions; unused bits read zero
  assign st_op_busy = !op_idle;
  assign st_serving = active_reg && !pdown_reg;

  always_comb begin
    status_view                                  = 32'h0000_0000;
    status_view[fcl_pkg::FCL_ST_OP_BUSY]         = st_op_busy;
    status_view[fcl_pkg::FCL_ST_SRC_LO +: 2]     = src_reg;
    status_view[fcl_pkg::FCL_ST_PE_ALLOWED]      = allowed_reg;
    status_view[fcl_pkg::FCL_ST_ACTIVE]          = st_serving;
    status_view[fcl_pkg::FCL_ST_READ_BUSY]       = rif.busy;
    status_view[fcl_pkg::FCL_ST_REFUSED_LO +: fcl_pkg::FCL_REFUSED_W] = refused_reg;
  end

  // Unmapped addresses answer zero
  assign rdata_next = !rd        ? 32'h0000_0000 :
                      hit_ctrl   ? ctrl_view :
                      hit_status ? status_view : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata           = rdata_reg;
  assign op_go           = op_go_reg;
  assign flash_active    = active_reg;
  assign flash_powerdown = pdown_reg;
  assign latch_preset    = preset_reg;
  assign async_read      = async_reg;
  assign read_src        = src_reg;
  assign program_sel     = prog_reg;
  assign erase_sel       = erase_reg;
  assign pe_allowed      = allowed_reg;
  // Beat answers come from the timer's own flip-flops
  assign beat_ready      = rif.beat_ready;
  assign buf_bypass      = rif.buf_bypass;

endmodule
`default_nettype wire

// file: include/fcl_pkg.sv
// Constants and types for the flash control lower bits block
package fcl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] FCL_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] FCL_STATUS_OFFSET = 12'h040;
  localparam logic [31:0] FCL_CTRL_RESET    = 32'h0000_0005;
  localparam logic [31:0] FCL_CTRL_WMASK    = 32'h0000_0EF7;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int FCL_SECTOR_LATCH_READ_SEL = 11;
  localparam int FCL_LATCH_PRESET          = 10;
  localparam int FCL_FLASH_POWERDOWN       = 9;
  localparam int FCL_RSVD_HI               = 8;
  localparam int FCL_PROG_ERASE_UNPROTECT  = 7;
  localparam int FCL_INDEX_SECTOR_SEL      = 6;
  localparam int FCL_DATA_LATCH_READ_SEL   = 5;
  localparam int FCL_ASYNC_READ_SEL        = 4;
  localparam int FCL_RSVD_LO               = 3;
  localparam int FCL_PROG_ERASE_ENABLE_N   = 2;
  localparam int FCL_PROGRAM_NOT_ERASE     = 1;
  localparam int FCL_FLASH_ACTIVE_SEL      = 0;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int FCL_ST_OP_BUSY    = 0;
  localparam int FCL_ST_SRC_LO     = 1;
  localparam int FCL_ST_PE_ALLOWED = 3;
  localparam int FCL_ST_ACTIVE     = 4;
  localparam int FCL_ST_READ_BUSY  = 5;
  localparam int FCL_ST_REFUSED_LO = 8;
  localparam int FCL_REFUSED_W     = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FCL_SRC_ARRAY        = 2'h0,
    FCL_SRC_SECTOR_LATCH = 2'h1,
    FCL_SRC_INDEX_SECTOR = 2'h2,
    FCL_SRC_DATA_LATCH   = 2'h3
  } fcl_read_src_t;

  typedef enum logic [1:0] {
    FCL_OP_IDLE = 2'h0,
    FCL_OP_RUN  = 2'h1,
    FCL_OP_DONE = 2'h3
  } fcl_op_state_t;

endpackage

// file: include/fcl_read_if.sv
// Read path signals between the control register and the beat timer
`timescale 1ns/10ps
`default_nettype none
interface fcl_read_if #(parameter int WST_W = 8);
  fcl_pkg::fcl_read_src_t read_src;
  logic                   async_read;
  logic                   enable;
  logic [WST_W-1:0]       wst;
  logic                   beat_req;
  logic                   beat_first;
  logic                   beat_ready;
  logic                   buf_bypass;
  logic                   busy;

  modport ctrl (output read_src, async_read, enable, wst, beat_req, beat_first,
                input beat_ready, buf_bypass, busy);
  modport path (input read_src, async_read, enable, wst, beat_req, beat_first,
                output beat_ready, buf_bypass, busy);
endinterface
`default_nettype wire

// file: rtl/fcl_read_path.sv
// Flash read beat timer with wait-state insertion
`timescale 1ns/10ps
`default_nettype none
module fcl_read_path #(
  parameter int WST_W = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control side
  fcl_read_if.path  rd
);

  logic [WST_W-1:0] count_reg;
  logic [WST_W-1:0] count_next;
  logic             busy_reg;
  logic             busy_next;
  logic             ready_reg;
  logic             ready_next;
  logic             bypass_reg;
  wire logic        special_src;
  wire logic        need_wait;
  wire logic        start;

  // ----------------------------------------
  // Beat timing
  // ----------------------------------------
  // Data latches and index sector never use the line buffer
  assign special_src = (rd.read_src == fcl_pkg::FCL_SRC_DATA_LATCH) ||
                       (rd.read_src == fcl_pkg::FCL_SRC_INDEX_SECTOR);
  // Buffered array bursts pay wait states only on the first beat
  assign need_wait   = special_src || rd.beat_first;
  assign start       = rd.beat_req && rd.enable && !busy_reg;

  always_comb begin
    count_next = count_reg;
    busy_next  = busy_reg;
    ready_next = 1'b0;
    if (start) begin
      if (need_wait && (rd.wst != '0)) begin
        count_next = rd.wst;
        busy_next  = 1'b1;
      end else begin
        ready_next = 1'b1;
      end
    end else if (busy_reg) begin
      count_next = count_reg - 1'b1;
      if (count_reg == {{(WST_W-1){1'b0}}, 1'b1}) begin
        busy_next  = 1'b0;
        ready_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg  <= '0;
      busy_reg   <= 1'b0;
      ready_reg  <= 1'b0;
      bypass_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      busy_reg   <= busy_next;
      ready_reg  <= ready_next;
      bypass_reg <= special_src;
    end
  end

  assign rd.beat_ready = ready_reg;
  assign rd.buf_bypass = bypass_reg;
  assign rd.busy       = busy_reg;

endmodule
`default_nettype wire

// file: bench/fcl_flash_model.sv
// Far-side model: flash data latches and the program/erase sequencer
`timescale 1ns/10ps
`default_nettype none
module fcl_flash_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Controls from the block, and the answer delay set by the test
  input  wire logic        op_go,
  input  wire logic        latch_preset,
  input  wire logic [3:0]  dly,
  // Answers
  output var  logic        op_done,
  output var  logic [31:0] latch_data
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg    <= 4'h0;
      op_done    <= 1'b0;
      latch_data <= 32'h0000_0000;
    end else begin
      // Delay set per operation so quick and slow answers both occur
      op_done <= (cnt_reg == 4'h1);
      cnt_reg <= op_go ? dly : cnt_reg - {3'h0, cnt_reg != 4'h0};
      if (latch_preset) latch_data <= 32'hFFFF_FFFF;
    end
  end
endmodule
`default_nettype wire

// file: bench/fcl_flash_control_properties.sv
// Concurrent checks on the flash control ports
`timescale 1ns/10ps
`default_nettype none
module fcl_props #(
  parameter int WST_W = 8
) (
  // Clock, reset and register port
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [11:0]      addr,
  input wire logic [31:0]      wdata,
  input wire logic             wr,
  input wire logic             rd,
  input wire logic [31:0]      rdata,
  // Beats and operations
  input wire logic [WST_W-1:0] wst_count,
  input wire logic             beat_req,
  input wire logic             beat_first,
  input wire logic             beat_ready,
  input wire logic             op_go,
  // Flash controls
  input wire logic             flash_active,
  input wire logic             flash_powerdown,
  input wire logic             latch_preset,
  input wire logic             async_read,
  input wire logic [1:0]       read_src,
  input wire logic             program_sel,
  input wire logic             erase_sel,
  input wire logic             pe_allowed
);
  // ----------------------------------------
  // Shadow of the control word
  // ----------------------------------------
  logic [31:0] sh_reg;
  logic [31:0] shd_reg;
  logic        bsy_reg;
  wire         taken = beat_req && !bsy_reg && sh_reg[0] && !sh_reg[9];
  wire  [1:0]  src_exp = shd_reg[5] ? 2'h3 : shd_reg[6] ? 2'h2 : {1'b0, shd_reg[11]};
  wire         pe_exp = shd_reg[7] && !shd_reg[2];
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_reg  <= 32'h0000_0005;
      shd_reg <= 32'h0000_0005;
      bsy_reg <= 1'b0;
    end else begin
      if (wr && addr == 12'h000) sh_reg <= wdata & 32'h0000_0EF7;
      shd_reg <= sh_reg;
      bsy_reg <= taken || (bsy_reg && !beat_ready);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_taken; taken; endsequence
  sequence s_slow; !beat_ready [*2] ##1 beat_ready; endsequence
  property p_active; flash_active == shd_reg[0]; endproperty
  property p_pdown; flash_powerdown == shd_reg[9]; endproperty
  property p_preset; latch_preset == shd_reg[10]; endproperty
  property p_async; async_read == shd_reg[4]; endproperty
  property p_src; read_src == src_exp; endproperty
  property p_pe; pe_allowed == pe_exp; endproperty
  property p_sel; program_sel == (pe_exp && shd_reg[1]) && erase_sel == (pe_exp && !shd_reg[1]);
  endproperty
  property p_read; rd && addr == 12'h000 |=> rdata == $past(sh_reg); endproperty
  property p_slow; s_taken ##0 (read_src[1] && wst_count == 2) |=> s_slow; endproperty
  property p_fast; s_taken ##0 (read_src == 2'h0 && !beat_first) |=> beat_ready; endproperty
  property p_op; op_go |-> pe_allowed && flash_active && !flash_powerdown; endproperty
  a_active: assert property (p_active) else $error("flash_active wrong");
  a_pdown: assert property (p_pdown) else $error("flash_powerdown wrong");
  a_preset: assert property (p_preset) else $error("latch_preset wrong");
  a_async: assert property (p_async) else $error("async_read wrong");
  a_src: assert property (p_src) else $error("read_src wrong");
  a_pe: assert property (p_pe) else $error("pe_allowed wrong");
  a_sel: assert property (p_sel) else $error("program or erase select wrong");
  a_read: assert property (p_read) else $error("control read wrong");
  a_slow: assert property (p_slow) else $error("bypassed beat timing wrong");
  a_fast: assert property (p_fast) else $error("array beat timing wrong");
  a_op: assert property (p_op) else $error("operation started while gated");
endmodule
bind fcl_flash_control fcl_props #(.WST_W(WST_W)) fcl_props_inst (.*);
`default_nettype wire

// file: bench/flash_control_lower_bits_test.sv
// Self-checking testbench for the flash control lower bits block
`timescale 1ns/10ps
`default_nettype none
module flash_control_lower_bits_test;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wst_count = 8'h02;
  logic        beat_req = 1'b0;
  logic        beat_first = 1'b0;
  logic        op_start = 1'b0;
  logic [3:0]  dly = 4'h1;
  logic [31:0] rdata, latch_data, v, c;
  logic        beat_ready, buf_bypass, op_go, op_done, flash_active, flash_powerdown;
  logic        latch_preset, async_read, program_sel, erase_sel, pe_allowed;
  logic [1:0]  read_src;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  wire  [8:0]  outs = {flash_active, flash_powerdown, latch_preset, async_read, read_src,
                       program_sel, erase_sel, pe_allowed};
  logic [31:0] corner [5] = '{32'hFFFF_FEF7, 32'h0000_0801, 32'h0000_0841, 32'h0000_0483,
                              32'h0000_0211};
  logic [31:0] b_ctrl [6] = '{32'h0000_0021, 32'h0000_0041, 32'h0000_0801, 32'h0000_0001,
                              32'h0000_0001, 32'h0000_0201};
  logic        b_first [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int          b_wait [6] = '{3, 3, 1, 1, 3, 8};
  always #50 clk = ~clk;
  fcl_flash_control #(.WST_W(8)) fcl_flash_control_inst (.*);
  fcl_flash_model fcl_flash_model_inst (.*);
  always @(posedge clk) begin
    cycles++;
    // Run needs well under a thousand cycles
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] exp_out(input logic [31:0] w);
    logic pe;
    pe = w[7] && !w[2];
    return {w[0], w[9], w[10], w[4], w[5] ? 2'h3 : w[6] ? 2'h2 : {1'b0, w[11]},
            pe && w[1], pe && !w[1], pe};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic beat(input logic f, input int exp);
    int n;
    n = 1;
    @(posedge clk);
    beat_req <= 1'b1;
    beat_first <= f;
    @(posedge clk);
    beat_req <= 1'b0;
    #1;
    while (beat_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("beat wait", 32'(n), 32'(exp));
  endtask
  task automatic op(input logic [31:0] w, input logic go, input logic [3:0] d);
    bus(1'b1, 12'h000, w);
    dly <= d;
    @(posedge clk);
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    #1;
    chk("op go", 32'(op_go), 32'(go));
    repeat (20) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset outputs", 32'(outs), 32'h0000_0100);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk("control reset", rdata, 32'h0000_0005);
    v = 32'h0001_554B;
    for (int i = 0; i < 30; i++) begin
      v = lfsr(v);
      c = (i < 5) ? corner[i] : (v & 32'h0000_0EF7);
      bus(1'b1, 12'h000, c);
      bus(1'b0, 12'h000, 32'h0000_0000);
      chk("control read", rdata, c & 32'h0000_0EF7);
      chk("controls", 32'(outs), 32'(exp_out(c)));
      if (c[10]) chk("latches", latch_data, 32'hFFFF_FFFF);
    end
    // Unmapped write must leave the control word alone
    bus(1'b1, 12'h044, 32'h0000_0000);
    bus(1'b0, 12'h000, 32'h0000_0000);
    chk("control kept", rdata, c & 32'h0000_0EF7);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 12'h000, b_ctrl[i]);
      beat(b_first[i], b_wait[i]);
      chk("bypass", 32'(buf_bypass), 32'(b_ctrl[i][5] | b_ctrl[i][6]));
    end
    // Longer and zero wait-state counts on the bypassed path
    @(posedge clk);
    wst_count <= 8'h05;
    bus(1'b1, 12'h000, 32'h0000_0021);
    beat(1'b0, 6);
    @(posedge clk);
    wst_count <= 8'h00;
    beat(1'b0, 1);
    @(posedge clk);
    wst_count <= 8'h02;
    op(32'h0000_0083, 1'b1, 4'h1);
    op(32'h0000_0081, 1'b1, 4'h9);
    op(32'h0000_0087, 1'b0, 4'h1);
    op(32'h0000_0003, 1'b0, 4'h1);
    bus(1'b0, 12'h040, 32'h0000_0000);
    chk("status", rdata, 32'h0000_0210);
    // Saturate the refused count, then clear it while starts keep being refused
    @(posedge clk);
    op_start <= 1'b1;
    repeat (260) @(posedge clk);
    op_start <= 1'b0;
    bus(1'b0, 12'h040, 32'h0000_0000);
    chk("refused full", rdata, 32'h0000_FF10);
    @(posedge clk);
    op_start <= 1'b1;
    bus(1'b1, 12'h040, 32'h0000_0000);
    @(posedge clk);
    op_start <= 1'b0;
    bus(1'b0, 12'h040, 32'h0000_0000);
    chk("refused cleared", rdata, 32'h0000_0210);
    end_of_test();
  end
endmodule
`default_nettype wire
